// file: design/tpi_pkg.sv
// How it works
// - lock command clears lock flag: keyboard shunted off loop, red lamp lit.
// - while lock flag is cleared, reading contacts cannot load the character register.
// - high load sets busy bit 5 and writes character msb into bit 5.
// - low load then writes the four low character bits.
// - transmit gives a 25 ms single pulse starting one distributor revolution.
// - each revolution opens the loop first as the start element.
// - then five data elements follow, bit 5 first, down to lowest bit.
// - loop is closed for a 1 bit and open for a 0 bit.
// - clear contact closes mid-revolution; its release resets the whole register.
// - keyboard strobe one-shot gates the five reading-contact bits into the register.
// - request button one-shot sets operator interrupt flag, lighting yellow lamp.
// - after a message processor reads interrupt flag; unlock sets lock flag, red lamp off.
// - character msb is 0 for printable and 1 for functional characters.
package tpi_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int START_PULSE_MS = 25;
  // element length of the cam, plain default
  localparam int ELEMENT_MS = 22;
  localparam int START_PULSE_CYCLES = START_PULSE_MS * (CLK_HZ / MS_PER_S);
  localparam int ELEMENT_CYCLES = ELEMENT_MS * (CLK_HZ / MS_PER_S);

  localparam int CHAR_W = 5;
  localparam int LOW_W = 4;
  localparam int MSB_IDX = 4;
  localparam int ELEM_W = 3;
  localparam logic [2:0] ELEM_START = 3'h0;
  localparam logic [2:0] ELEM_FIRST_DATA = 3'h1;
  localparam logic [2:0] ELEM_LAST_DATA = 3'h5;
  localparam logic [2:0] ELEM_CLEAR_CLOSE = 3'h3;
  localparam logic [2:0] ELEM_STOP = 3'h6;

  localparam logic [4:0] CHAR_CLEAR = 5'h00;
  localparam logic [4:0] ANS_BUSY_SET = 5'h10;
  localparam logic [4:0] ANS_FLAG_SET = 5'h01;
  localparam logic [4:0] ANS_ZERO = 5'h00;
  localparam logic KL_RESET = 1'b1;

  typedef enum logic [1:0] {
    TPI_ANS_BUSY,
    TPI_ANS_LOW,
    TPI_ANS_FLAG
  } tpi_ans_kind_t;
endpackage : tpi_pkg

// file: design/tpi_top.sv
module tpi_top #(
  parameter int START_PULSE_CYC = tpi_pkg::START_PULSE_CYCLES,
  parameter int ELEMENT_CYC = tpi_pkg::ELEMENT_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // processor commands, one-cycle strobes
  input wire logic lock_keyboard_command,
  input wire logic unlock_keyboard_command,
  input wire logic load_high_bits_command,
  input wire logic load_low_bits_command,
  input wire logic transmit_command,
  input wire logic read_busy_bit_command,
  input wire logic read_low_bits_command,
  input wire logic read_interrupt_flag_command,
  input wire logic [tpi_pkg::CHAR_W-1:0] processor_accumulator,
  output logic cmd_ready,
  // answers to the processor
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [tpi_pkg::CHAR_W-1:0] rd_data,
  output logic [1:0] rd_kind,
  // teleprinter pins, asynchronous
  input wire logic [tpi_pkg::CHAR_W-1:0] code_contacts,
  input wire logic char_strobe,
  input wire logic request_button,
  // teleprinter drives
  output logic loop_closed,
  output logic distributor_start_relay,
  output logic bit_five_relay,
  output logic lock_drive_relay,
  output logic signal_shunt_relay,
  output logic red_lamp,
  output logic request_lamp_relay,
  output logic end_of_revolution_relay,
  output logic busy_status
);
  localparam int PW = $clog2(START_PULSE_CYC + 1);
  localparam int EW = $clog2(ELEMENT_CYC + 1);
  localparam logic [PW-1:0] PULSE_LAST = PW'(START_PULSE_CYC - 1);
  localparam logic [EW-1:0] ELEM_LAST = EW'(ELEMENT_CYC - 1);
  localparam logic [PW-1:0] PULSE_ZERO = '0;
  localparam logic [EW-1:0] ELEM_ZERO = '0;
  // reset release
  logic rst_s1;
  logic rst_s2;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire logic rst_int_n = rst_s2;
  // pin synchronisers, third stage for edge detect
  logic [tpi_pkg::CHAR_W-1:0] code_s1;
  logic [tpi_pkg::CHAR_W-1:0] code_s2;
  logic strobe_s1;
  logic strobe_s2;
  logic strobe_s3;
  logic button_s1;
  logic button_s2;
  logic button_s3;
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      code_s1 <= tpi_pkg::CHAR_CLEAR;
      code_s2 <= tpi_pkg::CHAR_CLEAR;
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_s3 <= 1'b0;
      button_s1 <= 1'b0;
      button_s2 <= 1'b0;
      button_s3 <= 1'b0;
    end else begin
      code_s1 <= code_contacts;
      code_s2 <= code_s1;
      strobe_s1 <= char_strobe;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
      button_s1 <= request_button;
      button_s2 <= button_s1;
      button_s3 <= button_s2;
    end
  end
  logic strobe_shot;
  logic button_shot;
  assign strobe_shot = strobe_s2 && !strobe_s3;
  assign button_shot = button_s2 && !button_s3;
  logic kl_flag;
  logic op_flag;
  logic busy;
  logic [tpi_pkg::CHAR_W-1:0] char_bits;
  logic pulse_on;
  logic [PW-1:0] pulse_cnt;
  logic dist_run;
  logic [tpi_pkg::ELEM_W-1:0] elem_idx;
  logic [EW-1:0] elem_cnt;
  logic clear_contact;
  logic next_kl_flag;
  logic next_op_flag;
  logic next_busy;
  logic [tpi_pkg::CHAR_W-1:0] next_char_bits;
  logic next_pulse_on;
  logic [PW-1:0] next_pulse_cnt;
  logic next_dist_run;
  logic [tpi_pkg::ELEM_W-1:0] next_elem_idx;
  logic [EW-1:0] next_elem_cnt;
  logic next_clear_contact;
  logic next_loop;
  // answer buffer, two entries
  logic head_valid;
  logic tail_valid;
  logic [tpi_pkg::CHAR_W-1:0] head_data;
  logic [tpi_pkg::CHAR_W-1:0] tail_data;
  logic [1:0] head_kind;
  logic [1:0] tail_kind;
  logic next_head_valid;
  logic next_tail_valid;
  logic [tpi_pkg::CHAR_W-1:0] next_head_data;
  logic [tpi_pkg::CHAR_W-1:0] next_tail_data;
  logic [1:0] next_head_kind;
  logic [1:0] next_tail_kind;
  logic push;
  logic pop;
  logic low_read;
  logic [tpi_pkg::CHAR_W-1:0] push_data;
  logic [1:0] push_kind;
  logic rev_end;
  // read command decode, refused while the buffer is full
  always_comb begin
    push = 1'b0;
    low_read = 1'b0;
    push_data = tpi_pkg::ANS_ZERO;
    push_kind = 2'(tpi_pkg::TPI_ANS_BUSY);
    if (!tail_valid) begin
      if (read_busy_bit_command) begin
        push = 1'b1;
        push_data = busy ? tpi_pkg::ANS_BUSY_SET : tpi_pkg::ANS_ZERO;
        push_kind = 2'(tpi_pkg::TPI_ANS_BUSY);
      end else if (read_low_bits_command) begin
        push = 1'b1;
        low_read = 1'b1;
        push_data = char_bits;
        push_kind = 2'(tpi_pkg::TPI_ANS_LOW);
      end else if (read_interrupt_flag_command) begin
        push = 1'b1;
        push_data = op_flag ? tpi_pkg::ANS_FLAG_SET : tpi_pkg::ANS_ZERO;
        push_kind = 2'(tpi_pkg::TPI_ANS_FLAG);
      end
    end
  end
  assign pop = head_valid && rd_ready;
  always_comb begin
    next_head_valid = head_valid;
    next_head_data = head_data;
    next_head_kind = head_kind;
    next_tail_valid = tail_valid;
    next_tail_data = tail_data;
    next_tail_kind = tail_kind;
    if (pop) begin
      if (tail_valid) begin
        next_head_data = tail_data;
        next_head_kind = tail_kind;
        next_tail_valid = 1'b0;
      end else begin
        next_head_valid = push;
        next_head_data = push_data;
        next_head_kind = push_kind;
      end
    end else if (push) begin
      if (!head_valid) begin
        next_head_valid = 1'b1;
        next_head_data = push_data;
        next_head_kind = push_kind;
      end else begin
        next_tail_valid = 1'b1;
        next_tail_data = push_data;
        next_tail_kind = push_kind;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      head_valid <= 1'b0;
      tail_valid <= 1'b0;
      head_data <= tpi_pkg::ANS_ZERO;
      tail_data <= tpi_pkg::ANS_ZERO;
      head_kind <= 2'(tpi_pkg::TPI_ANS_BUSY);
      tail_kind <= 2'(tpi_pkg::TPI_ANS_BUSY);
    end else begin
      head_valid <= next_head_valid;
      tail_valid <= next_tail_valid;
      head_data <= next_head_data;
      tail_data <= next_tail_data;
      head_kind <= next_head_kind;
      tail_kind <= next_tail_kind;
    end
  end
  // flags, character register, start pulse and distributor
  always_comb begin
    next_kl_flag = kl_flag;
    next_op_flag = op_flag;
    next_busy = busy;
    next_char_bits = char_bits;
    next_pulse_on = pulse_on;
    next_pulse_cnt = pulse_cnt;
    next_dist_run = dist_run;
    next_elem_idx = elem_idx;
    next_elem_cnt = elem_cnt;
    rev_end = 1'b0;
    if (unlock_keyboard_command) begin
      next_kl_flag = 1'b1;
      next_op_flag = 1'b0;
    end
    if (lock_keyboard_command) begin
      next_kl_flag = 1'b0;
    end
    if (button_shot) begin
      next_op_flag = 1'b1;
    end
    if (pulse_on) begin
      if (pulse_cnt == PULSE_LAST) begin
        next_pulse_on = 1'b0;
      end else begin
        next_pulse_cnt = pulse_cnt + 1'b1;
      end
    end
    if (dist_run) begin
      if (elem_cnt == ELEM_LAST) begin
        next_elem_cnt = ELEM_ZERO;
        if (elem_idx == tpi_pkg::ELEM_STOP) begin
          next_dist_run = 1'b0;
          rev_end = 1'b1;
        end else begin
          next_elem_idx = elem_idx + 1'b1;
        end
      end else begin
        next_elem_cnt = elem_cnt + 1'b1;
      end
    end else if (transmit_command && !pulse_on) begin
      next_pulse_on = 1'b1;
      next_pulse_cnt = PULSE_ZERO;
      next_dist_run = 1'b1;
      next_elem_idx = tpi_pkg::ELEM_START;
      next_elem_cnt = ELEM_ZERO;
    end
    if (rev_end) begin
      next_busy = 1'b0;
      next_char_bits = tpi_pkg::CHAR_CLEAR;
    end else if (low_read && !(strobe_shot && kl_flag && !dist_run)) begin
      next_busy = 1'b0;
      next_char_bits = tpi_pkg::CHAR_CLEAR;
    end else if (!dist_run) begin
      if (load_high_bits_command) begin
        next_busy = 1'b1;
        next_char_bits[tpi_pkg::MSB_IDX] = processor_accumulator[tpi_pkg::MSB_IDX];
      end
      if (load_low_bits_command) begin
        next_char_bits[tpi_pkg::LOW_W-1:0] = processor_accumulator[tpi_pkg::LOW_W-1:0];
      end
      if (strobe_shot && kl_flag) begin
        next_busy = 1'b1;
        next_char_bits = code_s2;
      end
    end
    next_clear_contact = next_dist_run && (next_elem_idx >= tpi_pkg::ELEM_CLEAR_CLOSE);
    if (!next_dist_run) begin
      next_loop = 1'b1;
    end else if (next_elem_idx == tpi_pkg::ELEM_START) begin
      next_loop = 1'b0;
    end else if (next_elem_idx <= tpi_pkg::ELEM_LAST_DATA) begin
      // bit 5 first, then downward
      next_loop = next_char_bits[tpi_pkg::ELEM_LAST_DATA - next_elem_idx];
    end else begin
      next_loop = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      kl_flag <= tpi_pkg::KL_RESET;
      op_flag <= 1'b0;
      busy <= 1'b0;
      char_bits <= tpi_pkg::CHAR_CLEAR;
      pulse_on <= 1'b0;
      pulse_cnt <= PULSE_ZERO;
      dist_run <= 1'b0;
      elem_idx <= tpi_pkg::ELEM_START;
      elem_cnt <= ELEM_ZERO;
      clear_contact <= 1'b0;
    end else begin
      kl_flag <= next_kl_flag;
      op_flag <= next_op_flag;
      busy <= next_busy;
      char_bits <= next_char_bits;
      pulse_on <= next_pulse_on;
      pulse_cnt <= next_pulse_cnt;
      dist_run <= next_dist_run;
      elem_idx <= next_elem_idx;
      elem_cnt <= next_elem_cnt;
      clear_contact <= next_clear_contact;
    end
  end
  // registered outputs
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      loop_closed <= 1'b1;
      distributor_start_relay <= 1'b0;
      bit_five_relay <= 1'b0;
      lock_drive_relay <= ~tpi_pkg::KL_RESET;
      signal_shunt_relay <= tpi_pkg::KL_RESET;
      red_lamp <= ~tpi_pkg::KL_RESET;
      request_lamp_relay <= 1'b0;
      end_of_revolution_relay <= 1'b0;
      busy_status <= 1'b0;
      cmd_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= tpi_pkg::ANS_ZERO;
      rd_kind <= 2'(tpi_pkg::TPI_ANS_BUSY);
    end else begin
      loop_closed <= next_loop;
      distributor_start_relay <= next_pulse_on;
      bit_five_relay <= next_char_bits[tpi_pkg::MSB_IDX];
      // operated shunt relay keeps keyboard on the loop
      lock_drive_relay <= ~next_kl_flag;
      signal_shunt_relay <= next_kl_flag;
      red_lamp <= ~next_kl_flag;
      request_lamp_relay <= next_op_flag;
      end_of_revolution_relay <= next_clear_contact;
      busy_status <= next_busy;
      cmd_ready <= !next_tail_valid;
      rd_valid <= next_head_valid;
      rd_data <= next_head_data;
      rd_kind <= next_head_kind;
    end
  end
endmodule // tpi_top

// file: verif/tpi_top_monitor.sv
module tpi_monitor #(
  parameter int START_PULSE_CYC = 10,
  parameter int ELEMENT_CYC = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // processor side
  input wire logic lock_keyboard_command,
  input wire logic unlock_keyboard_command,
  input wire logic load_high_bits_command,
  input wire logic read_busy_bit_command,
  input wire logic cmd_ready,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [4:0] rd_data,
  input wire logic [1:0] rd_kind,
  // teleprinter side
  input wire logic loop_closed,
  input wire logic distributor_start_relay,
  input wire logic bit_five_relay,
  input wire logic signal_shunt_relay,
  input wire logic red_lamp,
  input wire logic end_of_revolution_relay,
  input wire logic busy_status
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CLR_AT = 3 * ELEMENT_CYC;
  localparam int CLR_LEN = 4 * ELEMENT_CYC;
  default clocking mon_cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_lock_lamp_on: assert property (
    lock_keyboard_command |-> ##[1:2] (red_lamp && !signal_shunt_relay))
    else $error("lock did not light lamp");
  a_shunt_lamp_tie: assert property (signal_shunt_relay == !red_lamp)
    else $error("shunt and lamp disagree");
  a_unlock_lamp_off: assert property (
    unlock_keyboard_command && !lock_keyboard_command |-> ##[1:2] signal_shunt_relay)
    else $error("unlock did not free keyboard");
  a_high_sets_busy: assert property (
    load_high_bits_command && !busy_status |-> ##[1:2] busy_status)
    else $error("high load did not set busy");
  a_start_then_msb: assert property (
    $rose(distributor_start_relay) |-> !loop_closed ##ELEMENT_CYC (loop_closed == bit_five_relay))
    else $error("start or first element wrong");
  a_pulse_length: assert property (
    $rose(distributor_start_relay) |-> ##START_PULSE_CYC $fell(distributor_start_relay))
    else $error("start pulse length wrong");
  a_clear_window: assert property (
    $rose(distributor_start_relay) |-> ##CLR_AT $rose(end_of_revolution_relay)
      ##CLR_LEN $fell(end_of_revolution_relay))
    else $error("clear contact timing wrong");
  a_clear_resets: assert property (
    $fell(end_of_revolution_relay) |-> ##[0:2] (!busy_status && !bit_five_relay))
    else $error("register not cleared");
  a_busy_answer: assert property (
    read_busy_bit_command && cmd_ready && !rd_valid |=>
      (rd_valid && rd_kind == 2'h0 && rd_data[3:0] == 4'h0))
    else $error("busy answer wrong");
  a_answer_holds: assert property (
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_data) && $stable(rd_kind))
    else $error("answer dropped while stalled");
endmodule // tpi_monitor

bind tpi_top tpi_monitor #(.START_PULSE_CYC(START_PULSE_CYC), .ELEMENT_CYC(ELEMENT_CYC)) u_mon (
  .ref_clk, .rst_n, .lock_keyboard_command, .unlock_keyboard_command, .load_high_bits_command,
  .read_busy_bit_command, .cmd_ready, .rd_valid, .rd_ready, .rd_data, .rd_kind, .loop_closed,
  .distributor_start_relay, .bit_five_relay, .signal_shunt_relay, .red_lamp,
  .end_of_revolution_relay, .busy_status
);

// file: verif/tpi_tty_model.sv
module tpi_tty_model #(
  parameter int ELEMENT_CYC = 8
) (
  // clock and loop
  input wire logic ref_clk,
  input wire logic loop_closed,
  input wire logic distributor_start_relay,
  // keyboard pins
  output logic [4:0] code_contacts,
  output logic char_strobe,
  output logic request_button,
  // decoded character
  output logic [4:0] got_char,
  output logic start_open,
  output int got_count
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    code_contacts = 5'h15;
    char_strobe = 1'b0;
    request_button = 1'b0;
    got_char = 5'h00;
    start_open = 1'b0;
    got_count = 0;
  end
  // sample the start element and the five data elements in their middles
  always @(posedge distributor_start_relay) begin
    repeat (ELEMENT_CYC / 2) @(posedge ref_clk);
    start_open = !loop_closed;
    for (int i = 4; i >= 0; i--) begin
      repeat (ELEMENT_CYC) @(posedge ref_clk);
      got_char[i] = loop_closed;
    end
    got_count = got_count + 1;
  end
  task automatic key_in(input logic [4:0] c);
    #1 code_contacts = c;
    repeat (3) @(posedge ref_clk);
    #1 char_strobe = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 char_strobe = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 code_contacts = ~c;
  endtask
  task automatic press_request();
    #1 request_button = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 request_button = 1'b0;
  endtask
endmodule // tpi_tty_model

// file: verif/tpi_top_tb_top.sv
module tpi_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ELEM = 8;
  // rows of {sent, received}
  localparam logic [9:0] ROWS [5] = '{10'h000, 10'h3FF, 10'h252, 10'h14A, 10'h2B5};
  logic ref_clk, rst_n, rd_ready, cmd_ready, rd_valid, loop_closed, distributor_start_relay;
  logic bit_five_relay, lock_drive_relay, signal_shunt_relay, red_lamp, request_lamp_relay;
  logic end_of_revolution_relay, busy_status, char_strobe, request_button, start_open;
  logic [7:0] cmd_v;
  logic [4:0] processor_accumulator, rd_data, code_contacts, got_char, ans;
  logic [1:0] rd_kind;
  int got_count, bad_count, checks_done, n, m;
  int cycles = 0;

  tpi_top #(.START_PULSE_CYC(10), .ELEMENT_CYC(ELEM)) dut (
    .ref_clk, .rst_n,
    .lock_keyboard_command(cmd_v[0]), .unlock_keyboard_command(cmd_v[1]),
    .load_high_bits_command(cmd_v[2]), .load_low_bits_command(cmd_v[3]),
    .transmit_command(cmd_v[4]), .read_busy_bit_command(cmd_v[5]),
    .read_low_bits_command(cmd_v[6]), .read_interrupt_flag_command(cmd_v[7]),
    .processor_accumulator, .cmd_ready, .rd_valid, .rd_ready, .rd_data, .rd_kind,
    .code_contacts, .char_strobe, .request_button, .loop_closed, .distributor_start_relay,
    .bit_five_relay, .lock_drive_relay, .signal_shunt_relay, .red_lamp, .request_lamp_relay,
    .end_of_revolution_relay, .busy_status
  );
  tpi_tty_model #(.ELEMENT_CYC(ELEM)) tty (
    .ref_clk, .loop_closed, .distributor_start_relay, .code_contacts, .char_strobe,
    .request_button, .got_char, .start_open, .got_count
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic issue(input int k, input logic [4:0] a);
    @(posedge ref_clk) #1 cmd_v = 8'h01 << k;
    processor_accumulator = a;
    @(posedge ref_clk) #1 cmd_v = 8'h00;
  endtask
  task automatic rd(input int k, input logic [1:0] kind, output logic [4:0] d);
    issue(k, 5'h00);
    for (int w = 0; w < 8; w++) begin
      @(posedge ref_clk);
      if (rd_valid === 1'b1) break;
    end
    check("answer", {5'h00, rd_valid, rd_kind}, {5'h00, 1'b1, kind});
    d = rd_data;
  endtask
  // one character out; mid set tries loads during the revolution
  task automatic tx_char(input logic [4:0] c, input logic [4:0] exp, input logic mid);
    issue(0, 5'h00);
    issue(2, c);
    rd(5, 2'h0, ans);
    check("busy after load", {3'h0, ans}, 8'h10);
    issue(3, c);
    n = got_count;
    issue(4, 5'h00);
    if (mid) begin
      repeat (12) @(posedge ref_clk);
      issue(2, ~c);
      issue(3, ~c);
    end
    for (int p = 0; p < 100; p++) begin
      rd(5, 2'h0, ans);
      if (ans === 5'h00) break;
    end
    check("rx count", 8'(got_count - n), 8'h01);
    check("rx char", {3'h0, got_char}, {3'h0, exp});
    check("start element", {7'h00, start_open}, 8'h01);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 30000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    cmd_v = 8'h00;
    processor_accumulator = 5'h00;
    rd_ready = 1'b1;
    repeat (8) @(posedge ref_clk);
    check("reset outputs", {2'h0, loop_closed, signal_shunt_relay, red_lamp, lock_drive_relay,
      busy_status, cmd_ready}, 8'h30);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int r = 0; r < 5; r++) begin
      tx_char(ROWS[r][9:5], ROWS[r][4:0], 1'b0);
    end
    tx_char(5'h1F, 5'h1F, 1'b1);
    tty.key_in(5'h07);
    rd(5, 2'h0, ans);
    check("locked print-in", {3'h0, ans}, 8'h00);
    tty.press_request();
    repeat (6) @(posedge ref_clk);
    rd(7, 2'h2, ans);
    check("request flag", {3'h0, ans}, 8'h01);
    check("lamps locked", {4'h0, red_lamp, lock_drive_relay, signal_shunt_relay,
      request_lamp_relay}, 8'h0D);
    issue(1, 5'h00);
    repeat (3) @(posedge ref_clk);
    check("lamps unlocked", {4'h0, red_lamp, lock_drive_relay, signal_shunt_relay,
      request_lamp_relay}, 8'h02);
    tty.key_in(5'h0B);
    repeat (4) @(posedge ref_clk);
    rd(5, 2'h0, ans);
    check("print-in busy", {3'h0, ans}, 8'h10);
    rd(6, 2'h1, ans);
    check("print-in char", {3'h0, ans}, 8'h0B);
    rd(5, 2'h0, ans);
    check("cleared by read", {3'h0, ans}, 8'h00);
    // stall the answer stream until reads are refused, then drain
    #1 rd_ready = 1'b0;
    n = 0;
    m = 0;
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk) #1 n = n + int'(cmd_ready === 1'b1);
      cmd_v = 8'h20;
      @(posedge ref_clk) #1 cmd_v = 8'h00;
    end
    check("refused when full", {7'h00, cmd_ready}, 8'h00);
    check("reads accepted", 8'(n), 8'h02);
    rd_ready = 1'b1;
    repeat (20) begin
      @(posedge ref_clk);
      if (rd_valid === 1'b1) m++;
    end
    check("answers kept", 8'(m), 8'h02);
    stop_test();
  end
endmodule // tpi_top_tb_top
